// [hdl/fcd_pkg.sv]
/*
 * Constants, codes and carrier types of the flash command sequencer.
 * Assumes a 20 MHz aclk and a parallel flash with a command port.
 */
//--------------------------------------------------------------------
// Functional notes
//--------------------------------------------------------------------
// Functional notes
// - Multi-cycle commands open with AAH at 5555H then 55H at 2AAAH.
// - F0H alone is read/reset; 75H and E0H take a location/data cycle.
// - Identification: prefix, 90H, then read at offset 00H or 01H.
// - Program: prefix, A0H, location/data; chip erase: prefix, 80H, prefix, 10H.
// - Block erase: prefix, 80H, prefix, 30H at the block-select address.
// - B0H alone suspends a block erase; 30H alone resumes it.
// - Prefix plus 70H selects status read; prefix plus 50H clears it.
// - Lock: prefix, 60H, prefix, 20H at block; sleep: prefix, C0H.
// - Lock status: prefix, 90H, then read at the lock query location.
package fcd_pkg;

    //----------------------------------------------------------------
    // Timing
    //----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_SETUP_NS = 50;
    localparam int T_PULSE_NS = 150;
    localparam int T_RECOVER_NS = 50;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    //----------------------------------------------------------------
    // Register map and fields
    //----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_CFG = 8'h14;
    localparam int CFG_BYTE_BIT = 0;
    localparam int CFG_PD_BIT = 1;
    localparam int CFG_TOP_BIT = 2;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_ERASE_BIT = 2;
    localparam int ST_ALG_BIT = 3;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    //----------------------------------------------------------------
    // Command codes and addresses
    //----------------------------------------------------------------
    localparam logic [14:0] CMD_ADDR1 = 15'h5555;
    localparam logic [14:0] CMD_ADDR2 = 15'h2aaa;
    localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [7:0] CODE_RESET = 8'hf0;
    localparam logic [7:0] CODE_ID = 8'h90;
    localparam logic [7:0] CODE_PROGRAM = 8'ha0;
    localparam logic [7:0] CODE_ERASE = 8'h80;
    localparam logic [7:0] CODE_CHIP = 8'h10;
    localparam logic [7:0] CODE_BLOCK = 8'h30;
    localparam logic [7:0] CODE_SUSPEND = 8'hb0;
    localparam logic [7:0] CODE_RESUME = 8'h30;
    localparam logic [7:0] CODE_SLEEP = 8'hc0;
    localparam logic [7:0] CODE_LOCK = 8'h60;
    localparam logic [7:0] CODE_LOCK_BLK = 8'h20;
    localparam logic [7:0] CODE_BUF_READ = 8'h75;
    localparam logic [7:0] CODE_BUF_WRITE = 8'he0;
    localparam logic [7:0] CODE_STAT_READ = 8'h70;
    localparam logic [7:0] CODE_STAT_CLR = 8'h50;
    localparam logic [7:0] CODE_BUF_CLR = 8'h04;
    localparam int DONE_FLAG_BIT = 7;
    localparam logic [19:0] LOCKQ_BOTTOM = 20'h00002;
    localparam logic [19:0] LOCKQ_TOP_BYTE = 20'hfff02;
    localparam logic [19:0] LOCKQ_TOP_WORD = 20'h7ff02;

    //----------------------------------------------------------------
    // Types
    //----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_READ, OP_RESET, OP_ID_READ, OP_PROGRAM, OP_CHIP_ERASE,
        OP_BLOCK_ERASE, OP_SUSPEND, OP_RESUME, OP_SLEEP, OP_LOCK,
        OP_LOCK_STATUS, OP_BUF_READ, OP_BUF_WRITE, OP_STAT_READ,
        OP_STAT_CLEAR, OP_BUF_CLEAR
    } fcd_op_type;

    typedef struct packed {
        logic rd;
        logic [18:0] addr;
        logic am1;
        logic [15:0] data;
    } fcd_cyc_type;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic powerdown_reset_n;
        logic byte_n;
        logic [18:0] addr;
        logic [15:0] dq_o;
        logic [15:0] dq_oe;
    } fcd_pins_type;

endpackage

// [hdl/fcd_host.sv]
/*
 * AXI4-Lite programmed sequencer that drives a parallel flash through
 * its pins: unlock prefixes, command codes, location/data and reads.
 * Assumes flash data inputs are synchronous to aclk and the bench
 * resolves the sixteen data lines from dq_oe.
 */
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fcd_host (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flash pins
    output fcd_pkg::fcd_pins_type flash_pins,
    input wire logic [15:0] flash_dq_i
);

    typedef enum {S_IDLE, S_SETUP, S_PULSE, S_RECOVER} fcd_seq_type;

    //----------------------------------------------------------------
    // State
    //----------------------------------------------------------------
    logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_axi_r, rdata_axi_nxt;
    logic [2:0] cfg_r, cfg_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic [15:0] data_r, data_nxt, rdata_r, rdata_nxt;
    fcd_pkg::fcd_op_type op_r, op_nxt;
    logic refused_r, refused_nxt, erase_r, erase_nxt, alg_r, alg_nxt;
    fcd_seq_type seq_r, seq_nxt;
    logic [2:0] step_r, step_nxt;
    logic [3:0] tmr_r, tmr_nxt;
    fcd_pkg::fcd_pins_type pins_r, pins_nxt;

    logic have_aw, have_w, do_write, do_read;
    logic [7:0] wr_addr;
    logic [31:0] wr_data, wr_merged, rd_word;
    logic [3:0] wr_strb;
    logic last_step;
    fcd_pkg::fcd_cyc_type cyc;

    //----------------------------------------------------------------
    // Helpers
    //----------------------------------------------------------------
    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Bus cycles in each sequence
    function automatic logic [2:0] nsteps(input fcd_pkg::fcd_op_type op);
        unique case (op)
            fcd_pkg::OP_READ, fcd_pkg::OP_RESET, fcd_pkg::OP_SUSPEND,
            fcd_pkg::OP_RESUME: nsteps = 3'h1;
            fcd_pkg::OP_SLEEP, fcd_pkg::OP_STAT_CLEAR,
            fcd_pkg::OP_BUF_CLEAR: nsteps = 3'h3;
            fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_BLOCK_ERASE,
            fcd_pkg::OP_LOCK: nsteps = 3'h6;
            default: nsteps = 3'h4;
        endcase
    endfunction

    // Third-cycle code, or the lone code of single-cycle commands
    function automatic logic [7:0] opcode(input fcd_pkg::fcd_op_type op);
        unique case (op)
            fcd_pkg::OP_RESET: opcode = fcd_pkg::CODE_RESET;
            fcd_pkg::OP_ID_READ, fcd_pkg::OP_LOCK_STATUS:
                opcode = fcd_pkg::CODE_ID;
            fcd_pkg::OP_PROGRAM: opcode = fcd_pkg::CODE_PROGRAM;
            fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_BLOCK_ERASE:
                opcode = fcd_pkg::CODE_ERASE;
            fcd_pkg::OP_SUSPEND: opcode = fcd_pkg::CODE_SUSPEND;
            fcd_pkg::OP_RESUME: opcode = fcd_pkg::CODE_RESUME;
            fcd_pkg::OP_SLEEP: opcode = fcd_pkg::CODE_SLEEP;
            fcd_pkg::OP_LOCK: opcode = fcd_pkg::CODE_LOCK;
            fcd_pkg::OP_BUF_READ: opcode = fcd_pkg::CODE_BUF_READ;
            fcd_pkg::OP_BUF_WRITE: opcode = fcd_pkg::CODE_BUF_WRITE;
            fcd_pkg::OP_STAT_READ: opcode = fcd_pkg::CODE_STAT_READ;
            fcd_pkg::OP_STAT_CLEAR: opcode = fcd_pkg::CODE_STAT_CLR;
            fcd_pkg::OP_BUF_CLEAR: opcode = fcd_pkg::CODE_BUF_CLR;
            default: opcode = 8'h00;
        endcase
    endfunction

    //----------------------------------------------------------------
    // Current bus cycle of the running sequence
    //----------------------------------------------------------------
    always_comb begin
        logic [19:0] loc;
        logic [7:0] fin;
        loc = addr_r;
        fin = (op_r == fcd_pkg::OP_CHIP_ERASE) ? fcd_pkg::CODE_CHIP :
            (op_r == fcd_pkg::OP_LOCK) ? fcd_pkg::CODE_LOCK_BLK :
            fcd_pkg::CODE_BLOCK;
        if (op_r == fcd_pkg::OP_LOCK_STATUS) begin
            loc = !cfg_r[fcd_pkg::CFG_TOP_BIT] ? fcd_pkg::LOCKQ_BOTTOM :
                cfg_r[fcd_pkg::CFG_BYTE_BIT] ? fcd_pkg::LOCKQ_TOP_BYTE :
                fcd_pkg::LOCKQ_TOP_WORD;
        end
        // Command cycles: A15-A18 low, code on lines 0-7 only
        cyc.rd = 1'b0;
        cyc.am1 = 1'b0;
        cyc.addr = {4'h0, fcd_pkg::CMD_ADDR1};
        cyc.data = {8'h00, opcode(op_r)};
        if (nsteps(op_r) == 3'h1) begin
            cyc.rd = (op_r == fcd_pkg::OP_READ);
        end else if (step_r == 3'h0 || step_r == 3'h3 &&
            nsteps(op_r) == 3'h6) begin
            cyc.data = {8'h00, fcd_pkg::CODE_UNLOCK1};
        end else if (step_r == 3'h1 || step_r == 3'h4) begin
            cyc.addr = {4'h0, fcd_pkg::CMD_ADDR2};
            cyc.data = {8'h00, fcd_pkg::CODE_UNLOCK2};
        end else if (step_r == 3'h5) begin
            cyc.data = {8'h00, fin};
        end
        // Location cycles: user location, or read of the chosen mode
        if ((nsteps(op_r) == 3'h1 && op_r == fcd_pkg::OP_READ) ||
            (step_r == 3'h3 && nsteps(op_r) == 3'h4) ||
            (step_r == 3'h5 && op_r != fcd_pkg::OP_CHIP_ERASE)) begin
            cyc.addr = cfg_r[fcd_pkg::CFG_BYTE_BIT] ? loc[19:1] :
                loc[18:0];
            cyc.am1 = cfg_r[fcd_pkg::CFG_BYTE_BIT] & loc[0];
        end
        if (step_r == 3'h3 && nsteps(op_r) == 3'h4) begin
            cyc.rd = (op_r == fcd_pkg::OP_ID_READ) ||
                (op_r == fcd_pkg::OP_LOCK_STATUS) ||
                (op_r == fcd_pkg::OP_STAT_READ);
            cyc.data = data_r;
        end
    end

    //----------------------------------------------------------------
    // AXI handshakes and register access
    //----------------------------------------------------------------
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_axi_r;
    assign flash_pins = pins_r;

    assign have_aw = aw_hold_r || s_axi_awvalid;
    assign have_w = w_hold_r || s_axi_wvalid;
    assign do_write = have_aw && have_w && !bvalid_r;
    assign do_read = s_axi_arvalid && !rvalid_r;
    assign wr_addr = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_hold_r ? w_data_r : s_axi_wdata;
    assign wr_strb = w_hold_r ? w_strb_r : s_axi_wstrb;
    assign last_step = (step_r == nsteps(op_r) - 3'h1);

    // Read-back word of the addressed register
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            fcd_pkg::REG_CTRL: rd_word = {28'h0, op_r};
            fcd_pkg::REG_ADDR: rd_word = {12'h000, addr_r};
            fcd_pkg::REG_DATA: rd_word = {16'h0000, data_r};
            fcd_pkg::REG_STATUS: rd_word = {28'h0, alg_r, erase_r,
                refused_r, seq_r != S_IDLE};
            fcd_pkg::REG_RDATA: rd_word = {16'h0000, rdata_r};
            fcd_pkg::REG_CFG: rd_word = {29'h0, cfg_r};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    //----------------------------------------------------------------
    // Next-state logic
    //----------------------------------------------------------------
    always_comb begin
        logic start;
        fcd_pkg::fcd_op_type req;
        start = 1'b0;
        wr_merged = merge(32'h0, wr_data, wr_strb);
        req = fcd_pkg::fcd_op_type'(wr_merged[3:0]);
        aw_hold_nxt = aw_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_hold_nxt = w_hold_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_axi_nxt = rdata_axi_r;
        cfg_nxt = cfg_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        op_nxt = op_r;
        refused_nxt = refused_r;
        erase_nxt = erase_r;
        alg_nxt = alg_r;
        rdata_nxt = rdata_r;
        seq_nxt = seq_r;
        step_nxt = step_r;
        tmr_nxt = tmr_r;
        // Address and data captured in whichever order they come
        if (s_axi_awvalid && s_axi_awready && !do_write) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !do_write) begin
            w_hold_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = fcd_pkg::RESP_OKAY;
            unique case (wr_addr)
                fcd_pkg::REG_CTRL: start = wr_strb[0];
                fcd_pkg::REG_ADDR: addr_nxt =
                    20'(merge({12'h000, addr_r}, wr_data, wr_strb));
                fcd_pkg::REG_DATA: data_nxt =
                    16'(merge({16'h0000, data_r}, wr_data, wr_strb));
                fcd_pkg::REG_STATUS: refused_nxt = refused_r &&
                    !(wr_strb[0] && wr_data[fcd_pkg::ST_REFUSED_BIT]);
                fcd_pkg::REG_RDATA: ;
                fcd_pkg::REG_CFG: cfg_nxt =
                    3'(merge({29'h0, cfg_r}, wr_data, wr_strb));
                default: bresp_nxt = fcd_pkg::RESP_SLVERR;
            endcase
        end
        if (do_read) begin
            rvalid_nxt = 1'b1;
            rdata_axi_nxt = rd_word;
            rresp_nxt = (s_axi_araddr > fcd_pkg::REG_CFG ||
                s_axi_araddr[1:0] != 2'h0) ? fcd_pkg::RESP_SLVERR :
                fcd_pkg::RESP_OKAY;
        end
        // Host refuses orders the flash would drop or mis-handle
        if (start) begin
            if (seq_r != S_IDLE || cfg_r[fcd_pkg::CFG_PD_BIT] ||
                ((req == fcd_pkg::OP_SUSPEND || req == fcd_pkg::OP_RESUME)
                && !erase_r) ||
                (req == fcd_pkg::OP_RESET && alg_r)) begin
                refused_nxt = 1'b1;
            end else begin
                op_nxt = req;
                step_nxt = 3'h0;
                seq_nxt = S_SETUP;
                tmr_nxt = 4'(fcd_pkg::SETUP_CYC - 1);
            end
        end
        // One bus cycle: setup, strobe low, recovery
        unique case (seq_r)
            S_IDLE: ;
            S_SETUP: if (tmr_r == 4'h0) begin
                seq_nxt = S_PULSE;
                tmr_nxt = 4'(fcd_pkg::PULSE_CYC - 1);
            end else begin
                tmr_nxt = tmr_r - 4'h1;
            end
            S_PULSE: if (tmr_r == 4'h0) begin
                seq_nxt = S_RECOVER;
                tmr_nxt = 4'(fcd_pkg::RECOVER_CYC - 1);
                if (cyc.rd) begin
                    rdata_nxt = cfg_r[fcd_pkg::CFG_BYTE_BIT] ?
                        {8'h00, flash_dq_i[7:0]} : flash_dq_i;
                end
            end else begin
                tmr_nxt = tmr_r - 4'h1;
            end
            S_RECOVER: if (tmr_r != 4'h0) begin
                tmr_nxt = tmr_r - 4'h1;
            end else if (last_step) begin
                seq_nxt = S_IDLE;
                if (op_r == fcd_pkg::OP_PROGRAM ||
                    op_r == fcd_pkg::OP_CHIP_ERASE ||
                    op_r == fcd_pkg::OP_BLOCK_ERASE) begin
                    alg_nxt = 1'b1;
                    erase_nxt = erase_r || op_r != fcd_pkg::OP_PROGRAM;
                end
                if (op_r == fcd_pkg::OP_STAT_READ &&
                    rdata_r[fcd_pkg::DONE_FLAG_BIT]) begin
                    alg_nxt = 1'b0;
                    erase_nxt = 1'b0;
                end
            end else begin
                step_nxt = step_r + 3'h1;
                seq_nxt = S_SETUP;
                tmr_nxt = 4'(fcd_pkg::SETUP_CYC - 1);
            end
        endcase
        // Pins follow the next sequencer state
        pins_nxt.powerdown_reset_n = !cfg_nxt[fcd_pkg::CFG_PD_BIT];
        pins_nxt.byte_n = !cfg_nxt[fcd_pkg::CFG_BYTE_BIT];
        pins_nxt.ce_n = (seq_nxt == S_IDLE);
        pins_nxt.oe_n = !(seq_nxt == S_PULSE && cyc.rd);
        pins_nxt.we_n = !(seq_nxt == S_PULSE && !cyc.rd);
        pins_nxt.addr = (seq_nxt == S_IDLE) ? 19'h00000 : cyc.addr;
        pins_nxt.dq_o = cyc.data;
        pins_nxt.dq_oe = 16'h0000;
        if (seq_nxt != S_IDLE && !cyc.rd) begin
            pins_nxt.dq_oe = cfg_nxt[fcd_pkg::CFG_BYTE_BIT] ?
                16'h00ff : 16'hffff;
        end
        if (cfg_nxt[fcd_pkg::CFG_BYTE_BIT]) begin
            pins_nxt.dq_o[15] = cyc.am1 && seq_nxt != S_IDLE;
            pins_nxt.dq_oe[15] = 1'b1;
        end
    end

    //----------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_hold_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= fcd_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= fcd_pkg::RESP_OKAY;
            rdata_axi_r <= 32'h0000_0000;
            cfg_r <= fcd_pkg::CFG_RESET;
            addr_r <= 20'h00000;
            data_r <= 16'h0000;
            op_r <= fcd_pkg::OP_READ;
            refused_r <= 1'b0;
            erase_r <= 1'b0;
            alg_r <= 1'b0;
            rdata_r <= 16'h0000;
            seq_r <= S_IDLE;
            step_r <= 3'h0;
            tmr_r <= 4'h0;
            pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                powerdown_reset_n: 1'b1, byte_n: 1'b1, addr: 19'h00000,
                dq_o: 16'h0000, dq_oe: 16'h0000};
        end else begin
            aw_hold_r <= aw_hold_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_hold_r <= w_hold_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_axi_r <= rdata_axi_nxt;
            cfg_r <= cfg_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            op_r <= op_nxt;
            refused_r <= refused_nxt;
            erase_r <= erase_nxt;
            alg_r <= alg_nxt;
            rdata_r <= rdata_nxt;
            seq_r <= seq_nxt;
            step_r <= step_nxt;
            tmr_r <= tmr_nxt;
            pins_r <= pins_nxt;
        end
    end

endmodule // fcd_host

// [testbench/fcd_chk.sv]
/* Assertions on the sequencer's AXI and flash pin ports.
   Assumes it is bound to fcd_host from the bench top file. */
`timescale 1ns/1ps
module fcd_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watched ports
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire fcd_pkg::fcd_pins_type flash_pins
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Strobe low for three cycles, then high
    sequence s_pulse;
        !flash_pins.we_n [*3] ##1 flash_pins.we_n;
    endsequence
    // Bus answers and pin relations
    a_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
    a_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r lost");
    a_aw_block: assert property (
        s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
    a_we_pulse: assert property (
        $fell(flash_pins.we_n) |-> s_pulse) else $error("bad pulse");
    a_we_sel: assert property (
        !flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n)
        else $error("bad strobe");
    a_oe_float: assert property (
        !flash_pins.oe_n |-> flash_pins.dq_oe[14:0] == 15'h0)
        else $error("drive in read");
    a_we_drive: assert property (
        !flash_pins.we_n |-> &flash_pins.dq_oe[7:0]) else $error("undriven");
    a_addr_hold: assert property (
        !flash_pins.we_n && !$past(flash_pins.we_n)
        |-> $stable(flash_pins.addr)) else $error("addr moved");
endmodule // fcd_chk

// [testbench/fcd_flash_model.sv]
/* Behavioural flash device answering the sequencer's pins.
   Assumes word mode; pin timing is left to the checker. */
`timescale 1ns/1ps
module fcd_flash_model #(
    parameter logic [15:0] MFR = 16'h005a, // Arbitrary value
    parameter logic [15:0] DEV = 16'h00a5 // Arbitrary value
) (
    // Pins from the host
    input wire fcd_pkg::fcd_pins_type pins,
    // Data lines towards the host
    output logic [15:0] dq
);
    logic [18:0] loc, prog_loc = 19'h0;
    logic [15:0] val, prog_val = 16'hffff;
    logic [1:0] mode = 2'h0;
    int step = 0;
    wire logic [7:0] c = pins.dq_o[7:0];
    wire logic [14:0] ad = loc[14:0];
    // Location on the strobe's fall
    always @(negedge pins.we_n) loc = pins.addr;
    // Command decode on the strobe's rise
    always @(posedge pins.we_n) begin
        if (step == 3) begin
            prog_loc = loc;
            prog_val = pins.dq_o;
            step = 0;
        end else if (step == 0 && c == 8'hf0) mode = 2'h0;
        else if (step == 0 && ad == 15'h5555 && c == 8'haa) step = 1;
        else if (step == 1 && ad == 15'h2aaa && c == 8'h55) step = 2;
        else if (step == 2 && ad == 15'h5555
            && c inside {8'h90, 8'h70, 8'ha0}) begin
            mode = c == 8'h90 ? 2'h1 : c == 8'h70 ? 2'h2 : 2'h0;
            step = c == 8'ha0 ? 3 : 0;
        end else begin
            mode = 2'h0;
            step = 0;
        end
    end
    // Read modes; lines flip when not read
    assign val = mode == 2'h1 ? (pins.addr[0] ? DEV : MFR)
        : mode == 2'h2 ? 16'h0080 : pins.addr == prog_loc ? prog_val
        : 16'hffff;
    assign dq = !pins.ce_n && !pins.oe_n && pins.powerdown_reset_n
        ? val : ~val;
endmodule // fcd_flash_model

// [testbench/fcd_host_bench.sv]
/* Bench top: AXI master, flash model and checker bind.
   Assumes word mode and the model's identification values. */
`timescale 1ns/1ps
module fcd_host_bench;
    localparam logic [15:0] MFR = 16'h005a; // Arbitrary value
    localparam logic [15:0] DEV = 16'h00a5; // Arbitrary value
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] flash_dq_i, dev_dq, v;
    fcd_pkg::fcd_pins_type flash_pins;
    int fail_count = 0, num_checks = 0;
    // Clock, resolved data lines, design and flash
    always #25 aclk = ~aclk;
    assign flash_dq_i = flash_pins.dq_oe & flash_pins.dq_o
        | ~flash_pins.dq_oe & dev_dq;
    fcd_host fcd_host_inst (.*);
    fcd_flash_model #(.MFR(MFR), .DEV(DEV)) fcd_flash_model_inst (
        .pins(flash_pins), .dq(dev_dq));
    // Compare, hang guard, verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic guard(input int n);
        if (n > 200) begin
            fail_count++;
            wrap_up();
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d fails=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One AXI write or read, held until taken and answered
    task automatic xfer(input logic w, input logic [7:0] a, input int d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        s_axi_bready <= w;
        s_axi_rready <= !w;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            guard(n++);
        end while (w ? s_axi_bvalid !== 1'h1 : s_axi_rvalid !== 1'h1);
        resp = w ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 0);
        check(rd, e);
    endtask
    // Start an operation and wait for busy to clear
    task automatic op(input logic [3:0] c);
        int n = 0;
        xfer(1'h1, 8'h00, c);
        do begin
            xfer(1'h0, 8'h0c, 0);
            guard(n++);
        end while (rd[0] !== 1'h0);
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h9758));
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        expect_reg(8'h0c, 32'h0);
        expect_reg(8'h14, 32'h0);
        xfer(1'h1, 8'h1c, 1);
        check(resp, 2'h2);
        expect_reg(8'h18, 32'h0);
        check(resp, 2'h2);
        for (int i = 0; i < 2; i++) begin
            xfer(1'h1, 8'h04, i);
            op(4'h2);
            expect_reg(8'h10, {16'h0, i ? DEV : MFR});
        end
        v = 16'($urandom);
        xfer(1'h1, 8'h04, $urandom & 32'h7ffff);
        xfer(1'h1, 8'h08, v);
        op(4'h3);
        op(4'h1);
        expect_reg(8'h0c, 32'ha);
        op(4'hd);
        expect_reg(8'h10, 32'h80);
        xfer(1'h1, 8'h0c, 2);
        op(4'h6);
        expect_reg(8'h0c, 32'h2);
        op(4'h1);
        op(4'h0);
        expect_reg(8'h10, {16'h0, v});
        xfer(1'h1, 8'h0c, 2);
        xfer(1'h1, 8'h14, 2);
        check(flash_pins.powerdown_reset_n, 1'h0);
        op(4'h2);
        expect_reg(8'h0c, 32'h2);
        wrap_up();
    end
endmodule // fcd_host_bench
bind fcd_host fcd_chk fcd_chk_inst (.*);
